/* core/wkd_top.v */
/*
  wake pin detector: filters the wake input, wakes the chip from sleep and
  fail-safe, raises edge flags with masks and an interrupt, and flags a
  pending wake at sleep entry. registers over axi4-lite.
  assumes the chip mode and an undervoltage-off indicator come from the
  chip state machine, and wake_input is sampled on clk_in.
*/
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "wkd_defs.vh"
// Behaviour
// - both rising and falling changes are wake events
// - accept level only after 10-25 us stable
// - software enables wake capability by control bit
// - below undervoltage off: pin hi-z, wakes ignored
// - live level readable in normal, stop, flash
// - enabled and sleeping: filtered edge wakes chip
// - in fail-safe any filtered edge forces restart
// - enabled active modes: edges set flags, interrupt
// - separate masks for rising and falling interrupts
// - pending flags at sleep entry cause rewake
// - edge during sleep command is not lost
module wkd_top #(
  parameter CNT_W = 10,
  parameter [CNT_W-1:0] FILT_CYC = `WKD_FILT_CYC
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire wake_input_in,
  output wire wake_input_oe_n_out,
  input wire undervoltage_off_in,
  input wire [2:0] chip_mode_in,
  input wire sleep_cmd_in,
  output wire wake_request_out,
  output wire restart_request_out,
  output wire irq_out,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);
  reg enable_r;
  reg [1:0] stat_r;
  wire [1:0] stat_nxt;
  reg [1:0] mask_r;
  reg wake_req_r;
  reg restart_req_r;
  reg sleep_pend_r;
  reg transit_ev_r;
  reg [3:0] awaddr_r;
  reg aw_have_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_have_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  wire pin_sync;
  wire level;
  wire rise;
  wire fall;
  wire powered;
  wire active_mode;
  wire in_sleep;
  wire in_failsafe;
  wire [1:0] ev;
  wire wr_fire;
  reg wr_ok;
  wire rd_fire;
  reg [31:0] rd_word;
  reg rd_ok;
  localparam N_EV = 2; // rising and falling edge flags
  genvar gi;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;

  // undervoltage off clears the requests, blocks new flags and holds the filter; flags already set still drive irq
  assign powered = ~undervoltage_off_in;
  assign active_mode = (chip_mode_in == `WKD_MODE_NORMAL) || (chip_mode_in == `WKD_MODE_STOP) ||
                       (chip_mode_in == `WKD_MODE_FLASH);
  assign in_sleep = (chip_mode_in == `WKD_MODE_SLEEP);
  assign in_failsafe = (chip_mode_in == `WKD_MODE_FAILSAFE);

  // pin is input only; output driver never enabled, so hi-z in off state too
  assign wake_input_oe_n_out = 1'b1;

  wkd_sync u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .d_in(wake_input_in),
    .q_out(pin_sync)
  );

  // count cleared while unpowered, so no count runs on across an outage
  wkd_filter #(
    .CNT_W(CNT_W),
    .FILT_CYC(FILT_CYC)
  ) u_filt (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(powered),
    .raw_in(pin_sync),
    .level_out(level),
    .rise_out(rise),
    .fall_out(fall)
  );

  // one-cycle pulses from the filter, one per direction
  assign ev[`WKD_EV_RISE] = rise;
  assign ev[`WKD_EV_FALL] = fall;

  // axi write: address and data taken in either order
  // a held beat or a pending response stalls the bus: one write at a time
  assign s_axi_awready = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready = ~w_have_r & ~bvalid_r;
  assign wr_addr = aw_have_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_have_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_have_r ? wstrb_r : s_axi_wstrb;
  assign wr_fire = (aw_have_r | (s_axi_awvalid & s_axi_awready)) &
                   (w_have_r | (s_axi_wvalid & s_axi_wready)) & ~bvalid_r;
  // only the four word offsets exist; anything else answers slverr,
  // so a stray unaligned write never lands on a register
  always @* begin
    case (wr_addr)
      `WKD_OFF_CTRL, `WKD_OFF_STAT, `WKD_OFF_MASK, `WKD_OFF_LEVEL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `WKD_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `WKD_RESP_OKAY : `WKD_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_have_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_have_r <= 1'b1;
          wdata_r <= s_axi_wdata;
          wstrb_r <= s_axi_wstrb;
        end
        if (bvalid_r & s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // control and mask registers
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_r <= `WKD_CTRL_RST;
      mask_r <= `WKD_MASK_RST;
    end else if (wr_fire && wr_strb[0]) begin
      if (wr_addr == `WKD_OFF_CTRL) begin
        enable_r <= wr_data[`WKD_CTRL_EN];
      end
      if (wr_addr == `WKD_OFF_MASK) begin
        mask_r <= wr_data[1:0];
      end
    end
  end

  // one sticky flag per edge kind; set beats write-one-to-clear so an
  // edge landing with the clear is never lost
  generate
    for (gi = 0; gi < N_EV; gi = gi + 1) begin : g_flag
      wire ev_clr;
      wire ev_set;
      assign ev_clr = wr_fire & wr_strb[0] & (wr_addr == `WKD_OFF_STAT) & wr_data[gi];
      assign ev_set = powered & enable_r & active_mode & ev[gi];
      assign stat_nxt[gi] = ev_set | (stat_r[gi] & ~ev_clr);
    end
  endgenerate

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stat_r <= `WKD_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // level output: stays up until software clears or masks the cause
  assign irq_out = |(stat_r & ~mask_r);

  // wake and restart requests, held until the chip leaves the mode
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_req_r <= 1'b0;
      restart_req_r <= 1'b0;
      sleep_pend_r <= 1'b0;
      transit_ev_r <= 1'b0;
    end else if (!powered) begin
      wake_req_r <= 1'b0;
      restart_req_r <= 1'b0;
      sleep_pend_r <= 1'b0;
      transit_ev_r <= 1'b0;
    end else begin
      // remember the sleep command until sleep is really reached
      if (sleep_cmd_in) begin
        sleep_pend_r <= 1'b1;
      end else if (in_sleep) begin
        sleep_pend_r <= 1'b0;
      end
      // edge taken between command and entry is kept for the wake;
      // covers chip states on the way that set no flag
      if (!sleep_cmd_in && !sleep_pend_r) begin
        transit_ev_r <= 1'b0;
      end else if (enable_r && (rise || fall) && !in_sleep) begin
        transit_ev_r <= 1'b1;
      end
      if (!in_sleep) begin
        wake_req_r <= 1'b0;
      end else if (enable_r && (rise || fall)) begin
        wake_req_r <= 1'b1;
      end else if (|stat_r) begin
        // flags left set, or set while the command ran
        wake_req_r <= 1'b1;
      end else if (transit_ev_r) begin
        wake_req_r <= 1'b1;
      end
      if (!in_failsafe) begin
        restart_req_r <= 1'b0;
      end else if (rise || fall) begin
        restart_req_r <= 1'b1;
      end
    end
  end

  assign wake_request_out = wake_req_r;
  assign restart_request_out = restart_req_r;

  // axi read; level reads as zero outside the modes that report it
  assign s_axi_arready = ~rvalid_r;
  assign rd_fire = s_axi_arvalid & ~rvalid_r;
  // read mux; unmapped offsets answer slverr with zero data
  always @* begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `WKD_OFF_CTRL: rd_word = {31'h0, enable_r};
      `WKD_OFF_STAT: rd_word = {30'h0, stat_r};
      `WKD_OFF_MASK: rd_word = {30'h0, mask_r};
      `WKD_OFF_LEVEL: rd_word = {31'h0, level & active_mode & powered};
      default: rd_ok = 1'b0;
    endcase
  end
  // data registered at the address handshake, held until rready

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `WKD_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_ok ? `WKD_RESP_OKAY : `WKD_RESP_SLVERR;
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule // wkd_top

/* core/wkd_defs.vh */
/*
  shared constants of the wake pin detector: bus offsets, field positions,
  reset values, chip mode codes and filter timing.
  assumes a 20 mhz system clock and inclusion by bare name.
*/
`ifndef WKD_DEFS_VH
`define WKD_DEFS_VH

// register byte offsets
`define WKD_OFF_CTRL 4'h0
`define WKD_OFF_STAT 4'h4
`define WKD_OFF_MASK 4'h8
`define WKD_OFF_LEVEL 4'hc

// field positions
`define WKD_CTRL_EN 0
`define WKD_EV_RISE 0
`define WKD_EV_FALL 1
`define WKD_LEVEL_BIT 0

// reset values
`define WKD_CTRL_RST 1'b0
`define WKD_MASK_RST 2'b11
`define WKD_STAT_RST 2'b00

// chip mode codes
`define WKD_MODE_NORMAL 3'h0
`define WKD_MODE_STOP 3'h1
`define WKD_MODE_FLASH 3'h2
`define WKD_MODE_SLEEP 3'h3
`define WKD_MODE_FAILSAFE 3'h4
`define WKD_MODE_RESTART 3'h5
`define WKD_MODE_INIT 3'h6

// filter timing
`define WKD_CLK_HZ 20000000
`define WKD_FILT_MIN_US 10
`define WKD_FILT_MAX_US 25
// aim near the middle of the window: 15 us
`define WKD_FILT_US 15
// 15 us of 50 ns cycles, sized for the 10-bit filter counter
`define WKD_FILT_CYC 10'd300

// axi responses
`define WKD_RESP_OKAY 2'b00
`define WKD_RESP_SLVERR 2'b10

`endif

/* core/wkd_filter.v */
/*
  glitch filter for the wake input: accepts a new level only after it held
  for the full count. assumes the input is already synchronous to clk_in.
*/
`timescale 1ns/1ns
module wkd_filter #(
  parameter CNT_W = 10,
  parameter [CNT_W-1:0] FILT_CYC = 10'd300
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire enable_in,
  input wire raw_in,
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);
  reg level_r;
  reg rise_r;
  reg fall_r;
  reg [CNT_W-1:0] cnt_r;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      cnt_r <= {CNT_W{1'b0}};
    end else begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      if (!enable_in) begin
        // count cleared while off; level kept so no false edge on return
        cnt_r <= {CNT_W{1'b0}};
      end else if (raw_in == level_r) begin
        cnt_r <= {CNT_W{1'b0}};
      end else if (cnt_r >= FILT_CYC - 1'b1) begin
        level_r <= raw_in;
        rise_r <= raw_in;
        fall_r <= ~raw_in;
        cnt_r <= {CNT_W{1'b0}};
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign level_out = level_r;
  assign rise_out = rise_r;
  assign fall_out = fall_r;
endmodule // wkd_filter

/* core/wkd_sync.v */
/*
  two-flop synchroniser for the raw wake line.
  assumes one clock; first stage feeds only the second.
*/
`timescale 1ns/1ns
module wkd_sync (
  input wire clk_in,
  input wire reset_n_in,
  input wire d_in,
  output wire q_out
);
  reg s1_r;
  reg s2_r;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
    end
  end

  assign q_out = s2_r;
endmodule // wkd_sync

/* sim/wkd_wake_line.sv */
/* wake line source: a switch on the pin.
   assumes the block clock; moves just after a rising edge. */
`timescale 1ns/1ns
module wkd_wake_line (
  input wire clk_in,
  output logic line_out
);
  initial line_out = 1'b0;
  // short holds stand for disturbances
  task drive(input logic lv, input int n);
    @(posedge clk_in);
    line_out <= lv;
    repeat (n) @(posedge clk_in);
  endtask
endmodule // wkd_wake_line

/* sim/wkd_top_sva.sv */
/* port checker of wkd_top.
   assumes binding into wkd_top; margins fit a filter count of 4. */
`timescale 1ns/1ns
`include "wkd_defs.vh"
module wkd_top_sva #(
  parameter CNT_W = 10,
  parameter [CNT_W-1:0] FILT_CYC = 4
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire wake_input_in,
  input wire wake_input_oe_n_out,
  input wire undervoltage_off_in,
  input wire [2:0] chip_mode_in,
  input wire wake_request_out,
  input wire restart_request_out,
  input wire irq_out,
  input wire s_axi_bvalid,
  input wire s_axi_bready
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic [7:0] stab_r;
  wire fs = chip_mode_in == `WKD_MODE_FAILSAFE && !undervoltage_off_in;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      stab_r <= 8'h00;
    else if ($changed(wake_input_in))
      stab_r <= 8'h00;
    else if (stab_r != 8'hff)
      stab_r <= stab_r + 8'h01;
  end
  // only a change away from a settled level; a revert inside the filter makes no edge
  sequence fs_edge;
    $changed(wake_input_in) && fs && stab_r >= 8'h08;
  endsequence
  // 8 cycles outlast sync plus filter
  sequence fs_hold;
    ($stable(wake_input_in) && fs)[*8];
  endsequence
  a_pin_not_driven: assert property (wake_input_oe_n_out) else $error("pin driven");
  a_uv_no_req: assert property (undervoltage_off_in |=> !wake_request_out && !restart_request_out)
    else $error("request in uv");
  a_wake_in_sleep: assert property (wake_request_out |-> $past(chip_mode_in) == `WKD_MODE_SLEEP)
    else $error("wake out of sleep");
  a_restart_in_fs: assert property (restart_request_out |-> $past(chip_mode_in) == `WKD_MODE_FAILSAFE)
    else $error("restart out of fs");
  a_filter_min_hold: assert property ($rose(restart_request_out) |-> $past(stab_r, 2) >= FILT_CYC - 2)
    else $error("short pulse taken");
  a_fs_edge_restart: assert property (fs_edge ##1 fs_hold |-> restart_request_out)
    else $error("no restart");
  a_irq_cause: assert property ($rose(irq_out) |-> $past(chip_mode_in) <= `WKD_MODE_FLASH || s_axi_bvalid)
    else $error("irq out of mode");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
endmodule // wkd_top_sva
bind wkd_top wkd_top_sva #(.CNT_W(CNT_W), .FILT_CYC(FILT_CYC)) chk (.*);

/* sim/testbench.sv */
/* bench of wkd_top: registers, edge flags, sleep and fail-safe wakes.
   assumes wkd_wake_line on the pin and the bound checker. */
`timescale 1ns/1ns
`include "wkd_defs.vh"
module testbench;
  localparam int WT = 12; // sync + filter of 4 + flag, with margin
  localparam logic [3:0] CT = `WKD_OFF_CTRL;
  localparam logic [3:0] ST = `WKD_OFF_STAT;
  localparam logic [3:0] MK = `WKD_OFF_MASK;
  localparam logic [3:0] LV = `WKD_OFF_LEVEL;
  logic clk_in = 1'b0, reset_n_in = 1'b0, uv = 1'b0, scmd = 1'b0;
  logic [2:0] mode = `WKD_MODE_NORMAL;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire pin, wreq, rreq, irq, awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int fails = 0;
  int n_checks = 0;
  always #25 clk_in = ~clk_in;
  wkd_wake_line wl (.clk_in(clk_in), .line_out(pin));
  wkd_top #(.FILT_CYC(10'h004)) uut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .wake_input_in(pin), .wake_input_oe_n_out(),
    .undervoltage_off_in(uv), .chip_mode_in(mode), .sleep_cmd_in(scmd), .wake_request_out(wreq),
    .restart_request_out(rreq), .irq_out(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task ck(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task tmo;
    fails++;
    $display("mismatch at %0t: wait ran out", $time);
    wrap_up;
  endtask
  // one bus access; valids drop on their own handshake edge
  task acc(input bit we, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = `WKD_RESP_OKAY);
    int i;
    @(posedge clk_in);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= we;
    wvalid <= we;
    bready <= we;
    arvalid <= !we;
    rready <= !we;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (i < 20 && bvalid !== 1'b1 && rvalid !== 1'b1);
    if (bvalid !== 1'b1 && rvalid !== 1'b1) tmo;
    bready <= 1'b0;
    rready <= 1'b0;
    ck(32'(we ? bresp : rresp), 32'(er));
    if (!we) ck(rdata, d);
  endtask
  // the sleep command leads the mode change by one cycle, as the chip acts on it
  task go(input logic [2:0] m);
    @(posedge clk_in);
    scmd <= (m == `WKD_MODE_SLEEP);
    @(posedge clk_in);
    mode <= m;
    scmd <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task t_regs;
    acc(0, CT, 32'h0);
    acc(0, MK, 32'h3);
    acc(0, LV, 32'h0);
    acc(0, 4'h2, 32'h0, `WKD_RESP_SLVERR);
    acc(1, 4'h2, 32'h1, `WKD_RESP_SLVERR);
  endtask
  task t_flags;
    int m;
    acc(1, CT, 32'h1);
    acc(1, MK, 32'h0);
    for (m = 0; m < 3; m++) begin
      go(3'(m));
      wl.drive(1'b1, WT);
      acc(0, LV, 32'h1);
      ck(32'(irq), 32'h1);
      wl.drive(1'b0, WT);
      acc(0, ST, 32'h3);
      acc(0, LV, 32'h0);
      acc(1, ST, 32'h3);
    end
    wl.drive(1'b1, WT);
    wl.drive(1'b0, 2);
    wl.drive(1'b1, WT);
    acc(0, ST, 32'h1);
    wl.drive(1'b0, WT);
    acc(1, MK, 32'h1);
    acc(1, ST, 32'h2);
    ck(32'(irq), 32'h0);
    acc(1, MK, 32'h2);
    ck(32'(irq), 32'h1);
    acc(1, ST, 32'h1);
    ck(32'(irq), 32'h0);
  endtask
  task t_sleep;
    go(`WKD_MODE_NORMAL);
    wl.drive(1'b1, WT);
    go(`WKD_MODE_SLEEP);
    ck(32'(wreq), 32'h1);
    go(`WKD_MODE_NORMAL);
    acc(1, ST, 32'h3);
    go(`WKD_MODE_SLEEP);
    ck(32'(wreq), 32'h0);
    wl.drive(1'b0, WT);
    ck(32'(wreq), 32'h1);
    go(`WKD_MODE_NORMAL);
    acc(1, CT, 32'h0);
    go(`WKD_MODE_SLEEP);
    wl.drive(1'b1, WT);
    ck(32'(wreq), 32'h0);
    go(`WKD_MODE_NORMAL);
    acc(1, CT, 32'h1);
    repeat (WT) @(posedge clk_in);
    acc(1, ST, 32'h3);
    // edge accepted in the very cycle the sleep command stands
    wl.drive(1'b0, 5);
    go(`WKD_MODE_SLEEP);
    repeat (WT) @(posedge clk_in);
    ck(32'(wreq), 32'h1);
    go(`WKD_MODE_NORMAL);
    acc(1, ST, 32'h3);
  endtask
  task t_fail;
    acc(1, CT, 32'h0);
    go(`WKD_MODE_FAILSAFE);
    wl.drive(1'b1, WT);
    ck(32'(rreq), 32'h1);
    acc(0, LV, 32'h0);
    go(`WKD_MODE_NORMAL);
    ck(32'(rreq), 32'h0);
    go(`WKD_MODE_FAILSAFE);
    wl.drive(1'b0, WT);
    ck(32'(rreq), 32'h1);
    go(`WKD_MODE_NORMAL);
    uv <= 1'b1;
    go(`WKD_MODE_FAILSAFE);
    wl.drive(1'b1, WT);
    ck(32'(rreq), 32'h0);
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    tmo;
  end
  initial begin
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_regs;
    t_flags;
    t_sleep;
    t_fail;
    wrap_up;
  end
endmodule // testbench
